// File: slc_core_model.sv
// Behavioural model of the core and the ext_irq0_pin pin source.
// Assumes the bench changes its commands just after rising edges.
`timescale 1ns/1ns

module slc_core_model (
  input wire logic i_clk_sys,  // Clock
  input wire logic i_rstn,  // Reset, active low
  input wire logic [3:0] i_cmd,  // Sleep, global flag, mask, other irq
  input wire logic i_pin,  // Pin level wanted by the bench
  input wire logic i_ext_irq0_pin_req,  // Request from the block
  input wire logic i_cpu_stop,  // Core halted
  output slc_pkg::slc_cpu_s o_cpu,  // Core signals
  output logic o_pin  // Pin as driven
);
  logic ack_ff;
  logic nxt_ack;

  // A running core takes a request every other cycle while it is held; a halted core cannot
  assign nxt_ack = i_ext_irq0_pin_req & ~ack_ff & ~i_cpu_stop;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) ack_ff <= 1'h0;
    else ack_ff <= nxt_ack;
  end

  // Software arms sleep right before the sleep pulse
  assign o_cpu = {i_cmd[3:1], ack_ff, i_cmd[0]};
  // Source holds the level for as long as the bench asks
  assign o_pin = i_pin;
endmodule : slc_core_model

// File: slc_map.svh
// Register map, field positions, reset values and timing counts of the
// sleep and external interrupt 0 control block.
// Assumes a 100 MHz system clock and word-aligned APB addressing.
`ifndef SLC_MAP_SVH
`define SLC_MAP_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define SLC_IDX_MCU_CTL 6'h35
`define SLC_IDX_EV_STAT 6'h36
`define SLC_IDX_EV_CLR 6'h37
`define SLC_IDX_EV_EN 6'h38

// ----------------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------------
`define SLC_BIT_ARM 5
`define SLC_BIT_DEPTH 4
`define SLC_SENSE_HI 1
`define SLC_SENSE_LO 0
`define SLC_MCU_WMASK 8'h33
`define SLC_MCU_RST 8'h00
`define SLC_SNS_LOW 2'h0
`define SLC_SNS_RSVD 2'h1
`define SLC_SNS_FALL 2'h2
`define SLC_SNS_RISE 2'h3

// ----------------------------------------------------------------------
// Event status bits
// ----------------------------------------------------------------------
`define SLC_EV_W 3
`define SLC_EV_EXT_IRQ0_PIN 0
`define SLC_EV_WAKE 1
`define SLC_EV_SLEEP 2
`define SLC_EV_RST 3'h0

// ----------------------------------------------------------------------
// Timing: reset delay time-out, least time, rounded up to cycles
// ----------------------------------------------------------------------
`define SLC_CLK_NS 10
`define SLC_TOUT_US 16
`define SLC_TOUT_CYC ((`SLC_TOUT_US * 1000 + `SLC_CLK_NS - 1) / `SLC_CLK_NS)
`define SLC_CNT_W 11

`endif

// File: slc_pkg.sv
// Types shared by the sleep and external interrupt 0 control block.
// Assumes the constants of slc_map.svh for widths of fields.
package slc_pkg;

  // Power state, one-hot
  typedef enum logic [2:0] {
    SLC_RUN = 3'h1,
    SLC_IDLE = 3'h2,
    SLC_PDOWN = 3'h4
  } slc_state_e;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } slc_apb_req_s;

  // Signals from the CPU core
  typedef struct packed {
    logic sleep_exec;  // Sleep instruction executed, one-cycle pulse
    logic global_irq_enable;  // Global flag of processor_flags
    logic ext_irq0_pin_mask;  // Mask bit of global_irq_mask_reg
    logic ext_irq0_pin_ack;  // Edge request taken by the core
    logic other_irq;  // Any other enabled internal interrupt
  } slc_cpu_s;

endpackage : slc_pkg

// File: slc_sleep_ext_irq0_pin_ctrl.sv
// Sleep mode control and external interrupt 0 sensing with an APB slave.
// Assumes pin and CPU inputs synchronous to i_clk_sys; reset wakes all.
//
// Contract
// [RULE1] Control register at 0x35, reserved bits zero
// [RULE2] Sleep instruction sleeps only when armed
// [RULE3] Software arms sleep just before sleeping
// [RULE4] Depth select: zero idle, one power-down
// [RULE5] Pin interrupt needs global flag and mask
// [RULE6] Sense field: low, reserved, falling, rising
// [RULE7] Pin sampled; pulses over one clock caught
// [RULE8] Source holds low until instruction completes
// [RULE9] Low level requests while pin stays low
// [RULE10] Enabled interrupt wakes, then resumes after sleep
// [RULE11] Reset during sleep wakes to reset vector
// [RULE12] Idle stops CPU, interrupts keep running
// [RULE13] Idle wake resumes with no delay
// [RULE14] Power-down stops oscillator, pin detection runs
// [RULE15] Only level interrupt or reset wakes power-down
// [RULE16] Wake level must outlast reset delay time-out
// [RULE17] Reserved sense code gives no request
// [RULE18] Edges compare current and previous samples
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns
`include "slc_map.svh"

module slc_sleep_ext_irq0_pin_ctrl (
  input wire logic i_clk_sys,  // System clock
  input wire logic i_rstn,  // Async reset, active low
  input wire slc_pkg::slc_apb_req_s i_apb,  // APB request
  output logic [31:0] o_prdata,  // APB read data
  output logic o_pready,  // APB ready
  output logic o_pslverr,  // APB error, unmapped address
  input wire slc_pkg::slc_cpu_s i_cpu,  // CPU core signals
  input wire logic i_ext_irq0_pin,  // External interrupt 0 pin
  output logic o_ext_irq0_pin_req,  // Interrupt request to the core
  output logic o_cpu_stop,  // CPU halted while sleeping
  output logic o_osc_stop,  // Oscillator stopped, power-down
  output logic o_wake,  // One-cycle pulse on wake-up
  output logic o_irq  // Block event interrupt, level
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------

  // Register hit: upper address bits zero, word index equal
  function automatic logic reg_hit(input logic [11:0] addr, input logic [5:0] idx);
    reg_hit = (addr[11:8] == 4'h0) && (addr[7:2] == idx);
  endfunction : reg_hit

  logic apb_setup;
  logic apb_wr;
  logic hit_ctl;
  logic hit_stat;
  logic hit_clr;
  logic hit_en;
  logic hit_any;
  assign apb_setup = i_apb.psel & ~i_apb.penable;
  assign apb_wr = i_apb.psel & i_apb.penable & i_apb.pwrite;
  assign hit_ctl = reg_hit(i_apb.paddr, `SLC_IDX_MCU_CTL);
  assign hit_stat = reg_hit(i_apb.paddr, `SLC_IDX_EV_STAT);
  assign hit_clr = reg_hit(i_apb.paddr, `SLC_IDX_EV_CLR);
  assign hit_en = reg_hit(i_apb.paddr, `SLC_IDX_EV_EN);
  assign hit_any = hit_ctl | hit_stat | hit_clr | hit_en;

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------

  logic [7:0] mcu_ctl_ff;
  logic [7:0] nxt_mcu_ctl;
  logic [1:0] sense;
  logic arm;
  logic depth;
  // Reserved bits never store, so they read zero
  assign nxt_mcu_ctl = (apb_wr && hit_ctl) ? (i_apb.pwdata[7:0] & `SLC_MCU_WMASK)
                                           : mcu_ctl_ff;  // RULE1
  assign sense = mcu_ctl_ff[`SLC_SENSE_HI:`SLC_SENSE_LO];
  assign arm = mcu_ctl_ff[`SLC_BIT_ARM];
  assign depth = mcu_ctl_ff[`SLC_BIT_DEPTH];

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      mcu_ctl_ff <= `SLC_MCU_RST;  // RULE1
    end else begin
      mcu_ctl_ff <= nxt_mcu_ctl;
    end
  end

  // ----------------------------------------------------------------------
  // Pin sampling and edge detection
  // ----------------------------------------------------------------------

  slc_pkg::slc_state_e st_ff;
  slc_pkg::slc_state_e nxt_st;
  logic pin_cur_ff;
  logic pin_prev_ff;
  logic pend_ff;
  logic nxt_pend;
  logic in_pdown;
  logic fall;
  logic rise;
  logic edge_hit;
  logic ext_irq0_pin_en;
  logic ext_irq0_pin_src;
  // Pin idles high; edges are blind in power-down since the clock is gone
  assign in_pdown = (st_ff == slc_pkg::SLC_PDOWN);
  assign fall = pin_prev_ff & ~pin_cur_ff;  // RULE18
  assign rise = ~pin_prev_ff & pin_cur_ff;  // RULE18
  assign edge_hit = ~in_pdown & (((sense == `SLC_SNS_FALL) & fall) |
                                 ((sense == `SLC_SNS_RISE) & rise));  // RULE6 RULE15
  // Edge request stays pending until the core takes it; a new edge wins
  assign nxt_pend = edge_hit | (pend_ff & ~i_cpu.ext_irq0_pin_ack);  // RULE7

  // Two samples so that any pulse held over one clock edge is seen
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_cur_ff <= 1'h1;
      pin_prev_ff <= 1'h1;
      pend_ff <= 1'h0;
    end else begin
      pin_cur_ff <= i_ext_irq0_pin;  // RULE7
      pin_prev_ff <= pin_cur_ff;  // RULE18
      pend_ff <= nxt_pend;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt request to the core
  // ----------------------------------------------------------------------

  // Level mode follows the sampled pin directly; reserved code is silent
  assign ext_irq0_pin_en = i_cpu.global_irq_enable & i_cpu.ext_irq0_pin_mask;  // RULE5
  assign ext_irq0_pin_src = (sense == `SLC_SNS_LOW) ? ~pin_cur_ff :
                    (sense == `SLC_SNS_RSVD) ? 1'h0 : pend_ff;  // RULE9 RULE17 RULE6
  assign o_ext_irq0_pin_req = ext_irq0_pin_en & ext_irq0_pin_src;  // RULE5

  // ----------------------------------------------------------------------
  // Power-down wake qualifier
  // ----------------------------------------------------------------------

  logic [`SLC_CNT_W-1:0] low_cnt_ff;
  logic [`SLC_CNT_W-1:0] nxt_low_cnt;
  logic low_run;
  logic cnt_full;
  logic pd_wake;
  // Counter saturates, so a long low level cannot wrap and re-arm
  assign low_run = in_pdown & ~pin_cur_ff & (sense == `SLC_SNS_LOW);
  assign cnt_full = (low_cnt_ff == `SLC_CNT_W'(`SLC_TOUT_CYC));
  assign nxt_low_cnt = !low_run ? '0 :
                       cnt_full ? low_cnt_ff : low_cnt_ff + `SLC_CNT_W'(1);  // RULE16
  // Only a low level held past the time-out wakes from power-down
  assign pd_wake = low_run & cnt_full & ext_irq0_pin_en;  // RULE15 RULE16

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      low_cnt_ff <= '0;
    end else begin
      low_cnt_ff <= nxt_low_cnt;
    end
  end

  // ----------------------------------------------------------------------
  // Sleep state machine
  // ----------------------------------------------------------------------

  logic sleep_go;
  logic idle_wake;
  logic wake_now;
  assign sleep_go = i_cpu.sleep_exec & arm;  // RULE2
  // Idle keeps every interrupt source live, internal ones included
  assign idle_wake = (st_ff == slc_pkg::SLC_IDLE) & (o_ext_irq0_pin_req | i_cpu.other_irq);  // RULE12
  assign wake_now = idle_wake | pd_wake;

  // Next state; the core itself resumes after the sleep instruction
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      slc_pkg::SLC_RUN: begin
        if (sleep_go) begin
          nxt_st = depth ? slc_pkg::SLC_PDOWN : slc_pkg::SLC_IDLE;  // RULE4
        end
      end
      slc_pkg::SLC_IDLE: begin
        if (idle_wake) begin
          nxt_st = slc_pkg::SLC_RUN;  // RULE13 RULE10
        end
      end
      slc_pkg::SLC_PDOWN: begin
        if (pd_wake) begin
          nxt_st = slc_pkg::SLC_RUN;  // RULE10
        end
      end
      default: begin
        nxt_st = slc_pkg::SLC_RUN;
      end
    endcase
  end

  // Reset from any state returns to run, which the core maps to its vector
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      st_ff <= slc_pkg::SLC_RUN;  // RULE11
      o_wake <= 1'h0;
    end else begin
      st_ff <= nxt_st;
      o_wake <= wake_now;  // RULE10
    end
  end

  assign o_cpu_stop = (st_ff != slc_pkg::SLC_RUN);  // RULE12
  assign o_osc_stop = in_pdown;  // RULE14

  // ----------------------------------------------------------------------
  // Event status, enable and interrupt
  // ----------------------------------------------------------------------

  logic [`SLC_EV_W-1:0] ev_stat_ff;
  logic [`SLC_EV_W-1:0] ev_en_ff;
  logic [`SLC_EV_W-1:0] ev_set;
  logic [`SLC_EV_W-1:0] ev_clr;
  assign ev_set[`SLC_EV_EXT_IRQ0_PIN] = o_ext_irq0_pin_req;
  assign ev_set[`SLC_EV_WAKE] = wake_now;
  assign ev_set[`SLC_EV_SLEEP] = (st_ff == slc_pkg::SLC_RUN) & sleep_go;
  assign ev_clr = (apb_wr && hit_clr) ? i_apb.pwdata[`SLC_EV_W-1:0] : '0;

  // Sticky bits; a set in the clearing cycle is kept
  genvar gi;
  generate
    for (gi = 0; gi < `SLC_EV_W; gi++) begin : g_ev
      always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
          ev_stat_ff[gi] <= 1'h0;
        end else begin
          ev_stat_ff[gi] <= ev_set[gi] | (ev_stat_ff[gi] & ~ev_clr[gi]);
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      ev_en_ff <= `SLC_EV_RST;
    end else if (apb_wr && hit_en) begin
      ev_en_ff <= i_apb.pwdata[`SLC_EV_W-1:0];
    end
  end

  assign o_irq = |(ev_stat_ff & ev_en_ff);

  // ----------------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------------

  // Read data is captured in the setup cycle, so access needs no wait
  logic [31:0] rd_mux;
  assign rd_mux = hit_ctl ? {24'h000000, mcu_ctl_ff} :
                  hit_stat ? {29'h0, ev_stat_ff} :
                  hit_en ? {29'h0, ev_en_ff} : 32'h00000000;
  assign o_pready = 1'b1;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      o_prdata <= 32'h00000000;
      o_pslverr <= 1'b0;
    end else if (apb_setup) begin
      o_prdata <= i_apb.pwrite ? 32'h00000000 : rd_mux;
      o_pslverr <= ~hit_any;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);

  sequence s_sleep_cmd;
    (st_ff == slc_pkg::SLC_RUN) && i_cpu.sleep_exec;
  endsequence

  property p_rsvd_zero;
    (mcu_ctl_ff & ~`SLC_MCU_WMASK) == 8'h00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("Reserved bits set"); // RULE1

  property p_unarmed;
    s_sleep_cmd ##0 !arm |=> (st_ff == slc_pkg::SLC_RUN) && !o_cpu_stop;
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("Slept while unarmed"); // RULE2

  property p_depth;
    s_sleep_cmd ##0 arm |=> (o_osc_stop == $past(depth)) && o_cpu_stop;
  endproperty
  a_depth: assert property (p_depth) else $error("Wrong sleep depth"); // RULE4

  property p_gate;
    !(i_cpu.global_irq_enable && i_cpu.ext_irq0_pin_mask) |-> !o_ext_irq0_pin_req;
  endproperty
  a_gate: assert property (p_gate) else $error("Request while masked"); // RULE5

  property p_level;
    ext_irq0_pin_en && (sense == `SLC_SNS_LOW) && !i_ext_irq0_pin |=> !ext_irq0_pin_en || o_ext_irq0_pin_req
      || (sense != `SLC_SNS_LOW) || pin_cur_ff;
  endproperty
  a_level: assert property (p_level) else $error("Low level not requested"); // RULE9

  property p_rsvd_sense;
    sense == `SLC_SNS_RSVD |-> !o_ext_irq0_pin_req;
  endproperty
  a_rsvd_sense: assert property (p_rsvd_sense) else $error("Reserved code requested"); // RULE17

  property p_fall;
    !in_pdown && sense == `SLC_SNS_FALL && pin_prev_ff && !pin_cur_ff |=> pend_ff;
  endproperty
  a_fall: assert property (p_fall) else $error("Falling edge lost"); // RULE18

  property p_pd_edges;
    in_pdown && sense != `SLC_SNS_LOW |=> in_pdown && !o_wake;
  endproperty
  a_pd_edges: assert property (p_pd_edges) else $error("Edge woke power-down"); // RULE15

  property p_pd_short;
    in_pdown && !cnt_full |=> in_pdown;
  endproperty
  a_pd_short: assert property (p_pd_short) else $error("Early power-down wake"); // RULE16

  property p_idle_wake;
    (st_ff == slc_pkg::SLC_IDLE) && i_cpu.other_irq |=> !o_cpu_stop ##0 o_wake;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("Idle wake delayed"); // RULE13

endmodule : slc_sleep_ext_irq0_pin_ctrl

// File: sleep_and_ext_irq0_control_tb.sv
// Self-checking bench of the sleep and ext_irq0_pin control block.
// Assumes the core model drives the core side and the pin.
`timescale 1ns/1ns
`include "slc_map.svh"

module sleep_and_ext_irq0_control_tb;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  slc_pkg::slc_apb_req_s apb = '0;
  slc_pkg::slc_cpu_s cpu;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, req, stop, osc, wake, irq, dpin, err;
  logic [3:0] cmd = 4'h0;  // Sleep, global flag, mask, other irq
  logic pin = 1'h1;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc_cnt = 0;
  localparam logic [11:0] A_CTL = {4'h0, `SLC_IDX_MCU_CTL, 2'h0};
  localparam logic [11:0] A_ST = {4'h0, `SLC_IDX_EV_STAT, 2'h0};
  localparam logic [11:0] A_CLR = {4'h0, `SLC_IDX_EV_CLR, 2'h0};
  localparam logic [11:0] A_EN = {4'h0, `SLC_IDX_EV_EN, 2'h0};

  slc_sleep_ext_irq0_pin_ctrl u_dut (.i_clk_sys(clk), .i_rstn(rstn), .i_apb(apb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_cpu(cpu), .i_ext_irq0_pin(dpin),
    .o_ext_irq0_pin_req(req), .o_cpu_stop(stop), .o_osc_stop(osc), .o_wake(wake), .o_irq(irq));
  slc_core_model u_core (.i_clk_sys(clk), .i_rstn(rstn), .i_cmd(cmd), .i_pin(pin),
    .i_ext_irq0_pin_req(req), .i_cpu_stop(stop), .o_cpu(cpu), .o_pin(dpin));

  always #5 clk = ~clk;

  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 10000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] b1(input logic x);
    return {31'h0, x};
  endfunction : b1

  task give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Leaves just after an edge so outputs have settled
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Zero wait states are not assumed; only the guard ends the wait
  task apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    apb <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk);
    apb.penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    apb <= '0;
  endtask : apb_xfer

  task rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb_xfer(1'h0, a, 32'h0);
    chk(nm, rd, exp);
  endtask : rchk

  // Pin low for w cycles, then watch the request for eight
  task pulse(input int w, output logic saw);
    saw = 1'h0;
    @(posedge clk) pin <= 1'h0;
    repeat (w) @(posedge clk);
    pin <= 1'h1;
    repeat (8) begin
      #1 saw = saw | (req === 1'h1);
      @(posedge clk);
    end
  endtask : pulse

  task go_sleep;
    @(posedge clk) cmd <= 4'hE;
    @(posedge clk) cmd <= 4'h6;
    #1;
  endtask : go_sleep

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_regs;
    rchk("ctl_rst", A_CTL, 32'h0);
    rchk("st_rst", A_ST, 32'h0);
    rchk("en_rst", A_EN, 32'h0);
    apb_xfer(1'h1, A_CTL, 32'hFF);
    rchk("ctl_rsvd", A_CTL, 32'h33);
    rchk("clr_rd", A_CLR, 32'h0);
    apb_xfer(1'h0, 12'h0FC, 32'h0);
    chk("unmapped", b1(err), 32'h1);
  endtask : t_regs

  task t_sense;
    logic saw;
    @(posedge clk) cmd <= 4'h6;
    for (int m = 0; m < 4; m++) begin
      apb_xfer(1'h1, A_CTL, 32'(m));
      pulse(2, saw);
      chk("sense_req", b1(saw), b1(m != 1));
      tick(2);
      chk("req_quiet", b1(req), 32'h0);
    end
    @(posedge clk) cmd <= 4'h4;
    pulse(2, saw);
    chk("no_mask", b1(saw), 32'h0);
    @(posedge clk) cmd <= 4'h2;
    pulse(2, saw);
    chk("no_flag", b1(saw), 32'h0);
    apb_xfer(1'h1, A_CTL, 32'h0);
    @(posedge clk) cmd <= 4'h6;
    @(posedge clk) pin <= 1'h0;
    tick(12);
    chk("lvl_hold", b1(req), 32'h1);
    @(posedge clk) pin <= 1'h1;
    tick(4);
    chk("lvl_gone", b1(req), 32'h0);
  endtask : t_sense

  task t_idle;
    apb_xfer(1'h1, A_CTL, 32'h1);
    go_sleep();
    tick(1);
    chk("no_arm", b1(stop), 32'h0);
    apb_xfer(1'h1, A_CTL, 32'h21);
    go_sleep();
    chk("idle_stop", {30'h0, stop, osc}, 32'h2);
    tick(5);
    chk("idle_held", b1(stop), 32'h1);
    @(posedge clk) cmd <= 4'h7;
    @(posedge clk) cmd <= 4'h6;
    #1 chk("idle_wake", {30'h0, stop, wake}, 32'h1);
    tick(1);
    chk("wake_pulse", b1(wake), 32'h0);
    rchk("ctl_kept", A_CTL, 32'h21);
    // Idle must also wake on the pin request, not only internal ones
    apb_xfer(1'h1, A_CTL, 32'h20);
    go_sleep();
    @(posedge clk) pin <= 1'h0;
    tick(3);
    chk("idle_pin_wake", b1(stop), 32'h0);
    @(posedge clk) pin <= 1'h1;
    tick(2);
  endtask : t_idle

  task t_pdown;
    int n;
    logic saw;
    apb_xfer(1'h1, A_CTL, 32'h32);
    go_sleep();
    chk("pd_stop", {30'h0, stop, osc}, 32'h3);
    pulse(3, saw);
    chk("pd_edge", {30'h0, stop, saw}, 32'h2);
    apb_xfer(1'h1, A_CTL, 32'h30);
    @(posedge clk) pin <= 1'h0;
    repeat (100) @(posedge clk);
    pin <= 1'h1;
    tick(4);
    chk("pd_short", b1(stop), 32'h1);
    @(posedge clk) pin <= 1'h0;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (stop === 1'h1 && n < 1700);
    chk("pd_wake", b1(n > `SLC_TOUT_CYC && n < `SLC_TOUT_CYC + 6), 32'h1);
    @(posedge clk) pin <= 1'h1;
    tick(4);
  endtask : t_pdown

  task t_irq;
    rchk("st_sticky", A_ST, 32'h7);
    chk("irq_off", b1(irq), 32'h0);
    apb_xfer(1'h1, A_EN, 32'h2);
    tick(1);
    chk("irq_on", b1(irq), 32'h1);
    apb_xfer(1'h1, A_CLR, 32'h7);
    apb_xfer(1'h1, A_ST, 32'h7);
    rchk("st_clr", A_ST, 32'h0);
    chk("irq_clr", b1(irq), 32'h0);
  endtask : t_irq

  task t_rst;
    go_sleep();
    @(posedge clk) rstn <= 1'h0;
    tick(2);
    @(posedge clk) rstn <= 1'h1;
    tick(1);
    chk("rst_wake", {30'h0, stop, osc}, 32'h0);
    rchk("rst_ctl", A_CTL, 32'h0);
  endtask : t_rst

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    t_regs();
    t_sense();
    t_idle();
    t_pdown();
    t_irq();
    t_rst();
    give_verdict();
  end
endmodule : sleep_and_ext_irq0_control_tb
